// ---- rtl/pss_defs.svh ----
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
`define PSS_ADDR_W   17
`define PSS_DATA_W   36
`define PSS_BYTES    4
`define PSS_DEPTH    131072
`define PSS_LAT      2
`define PSS_LANE_W   9
`define PSS_BW_IDLE  4'hF
`endif

// ---- rtl/pss_pkg.sv ----
package pss_pkg;
  typedef enum logic [2:0] {
    PSS_IDLE  = 3'h1,
    PSS_READ  = 3'h2,
    PSS_WRITE = 3'h4
  } pss_op_e;
endpackage

// ---- rtl/pss_if.sv ----
`timescale 1ns/1ps
`include "pss_defs.svh"
interface pss_if;
  logic [`PSS_ADDR_W-1:0] addr;
  logic                   read_write_n;
  logic                   advance_or_load;
  logic                   chip_sel_a_n;
  logic                   chip_sel_b;
  logic                   chip_sel_c_n;
  logic                   clock_hold_n;
  logic [`PSS_BYTES-1:0]  byte_write_n;
  logic                   burst_order_n;
  logic [`PSS_DATA_W-1:0] dq_ctl_o;
  logic                   dq_ctl_oe;
  logic [`PSS_DATA_W-1:0] dq_mem_o;
  logic                   dq_mem_oe;
  modport mem (input addr, read_write_n, advance_or_load, chip_sel_a_n, chip_sel_b,
               chip_sel_c_n, clock_hold_n, byte_write_n, burst_order_n, dq_ctl_o,
               dq_ctl_oe, output dq_mem_o, dq_mem_oe);
  modport ctl (output addr, read_write_n, advance_or_load, chip_sel_a_n, chip_sel_b,
               chip_sel_c_n, clock_hold_n, byte_write_n, burst_order_n, dq_ctl_o,
               dq_ctl_oe, input dq_mem_o, dq_mem_oe);
endinterface

// ---- rtl/pss_sram.sv ----
// Operation
// - Selected only when a low, c low, b high
// - Write data taken two enabled edges after load
// - Pending read completes across deselect cycle
// - Read data driven one enabled edge after load; else Z
// - Controller drives write data two cycles later
// - Write data accepted in deselected second cycle
// - Data outputs high impedance from first edge
// - Held edge changes no internal register
// - Direction fixed at load, ignored bursting
// - Controller holds byte writes valid on writes
`timescale 1ns/1ps
`include "pss_defs.svh"
module pss_sram
  import pss_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  pss_if.mem       bus
);
  // Word storage; never cleared, so early reads give unknowns
  logic [`PSS_DATA_W-1:0] mem_q [0:`PSS_DEPTH-1];

  // Stage one: the access loaded or advanced last
  pss_op_e                op1_ff;
  logic [`PSS_ADDR_W-1:0] a1_ff;
  logic [`PSS_BYTES-1:0]  bw1_ff;

  // Stage two: the access whose data moves this cycle
  pss_op_e                op2_ff;
  logic [`PSS_ADDR_W-1:0] a2_ff;
  logic [`PSS_BYTES-1:0]  bw2_ff;

  // Burst state: direction, base address and word count
  pss_op_e                burst_op_ff;
  logic [`PSS_ADDR_W-1:0] base_ff;
  logic [1:0]             cnt_ff;

  // Output register and its enable
  logic [`PSS_DATA_W-1:0] q_ff;
  logic                   oe_ff;

  // Burst order: linear adds, interleaved xors
  function automatic logic [1:0] pss_seq(
    input logic [1:0] b,
    input logic [1:0] c,
    input logic       lin_mode
  );
    if (lin_mode) begin
      pss_seq = 2'(b + c);
    end else begin
      pss_seq = b ^ c;
    end
  endfunction

  // Direction of a fresh load; deselected loads start nothing
  function automatic pss_op_e pss_load_op(
    input logic selected,
    input logic is_read
  );
    if (!selected) begin
      pss_load_op = PSS_IDLE;
    end else if (is_read) begin
      pss_load_op = PSS_READ;
    end else begin
      pss_load_op = PSS_WRITE;
    end
  endfunction

  // Lanes whose strobe is low take the new word
  function automatic logic [`PSS_DATA_W-1:0] pss_merge(
    input logic [`PSS_DATA_W-1:0] old_word,
    input logic [`PSS_DATA_W-1:0] new_word,
    input logic [`PSS_BYTES-1:0]  lane_n
  );
    pss_merge = old_word;
    for (int i = 0; i < `PSS_BYTES; i++) begin
      if (!lane_n[i]) begin
        pss_merge[i*`PSS_LANE_W +: `PSS_LANE_W] = new_word[i*`PSS_LANE_W +: `PSS_LANE_W];
      end
    end
  endfunction

  // The three selects; any one inactive deselects
  wire sel_a = ~bus.chip_sel_a_n;
  wire sel_b = bus.chip_sel_b;
  wire sel_c = ~bus.chip_sel_c_n;
  wire sel   = sel_a & sel_b & sel_c;

  // Hold and load decode; a high hold pin blocks the whole edge
  wire en   = ~bus.clock_hold_n;
  wire load = ~bus.advance_or_load;
  wire lin  = ~bus.burst_order_n;

  // Burst address: low two bits walk, the rest stay put
  wire [1:0]             cnt_inc    = 2'(cnt_ff + 2'h1);
  wire [1:0]             burst_low  = pss_seq(base_ff[1:0], cnt_inc, lin);
  wire [`PSS_ADDR_W-1:0] burst_addr = {base_ff[`PSS_ADDR_W-1:2], burst_low};

  // Direction fixed at the load; bursting reuses the latched op
  wire pss_op_e          load_op    = pss_load_op(sel, bus.read_write_n);
  wire pss_op_e          nxt_op1    = load ? load_op : burst_op_ff;
  wire [`PSS_ADDR_W-1:0] nxt_a1     = load ? bus.addr : burst_addr;
  wire [`PSS_ADDR_W-1:0] nxt_base   = load ? bus.addr : base_ff;
  wire [1:0]             nxt_cnt    = load ? 2'h0 : cnt_inc;

  // Stage decode
  wire rd1 = (op1_ff == PSS_READ);
  wire wr2 = (op2_ff == PSS_WRITE);

  // Write lands at the second enabled edge, selected or not;
  // a deselect after the load does not cancel it
  wire wr_land = en & wr2;

  // A read right behind a write to the same word sees the new lanes,
  // because the array itself only changes at this same edge
  wire                   rd_fwd   = wr_land & (a2_ff == a1_ff);
  wire [`PSS_DATA_W-1:0] stored   = mem_q[a1_ff];
  wire [`PSS_DATA_W-1:0] fwd_word = pss_merge(stored, bus.dq_ctl_o, bw2_ff);
  wire [`PSS_DATA_W-1:0] nxt_q    = rd_fwd ? fwd_word : stored;
  wire                   nxt_oe   = rd1;

  // Stage one op; frozen while the clock is held
  always_ff @(posedge clk) begin
    if (rst) begin
      op1_ff <= PSS_IDLE;
    end else if (en) begin
      op1_ff <= nxt_op1;
    end
  end

  // Stage one address and strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      a1_ff  <= '0;
      bw1_ff <= `PSS_BW_IDLE;
    end else if (en) begin
      a1_ff  <= nxt_a1;
      bw1_ff <= bus.byte_write_n;
    end
  end

  // Stage two op; pending work survives deselects
  always_ff @(posedge clk) begin
    if (rst) begin
      op2_ff <= PSS_IDLE;
    end else if (en) begin
      op2_ff <= op1_ff;
    end
  end

  // Stage two address; strobes travel with the access to meet data
  always_ff @(posedge clk) begin
    if (rst) begin
      a2_ff  <= '0;
      bw2_ff <= `PSS_BW_IDLE;
    end else if (en) begin
      a2_ff  <= a1_ff;
      bw2_ff <= bw1_ff;
    end
  end

  // Burst direction; a deselect with advance low ends the burst
  always_ff @(posedge clk) begin
    if (rst) begin
      burst_op_ff <= PSS_IDLE;
    end else if (en) begin
      burst_op_ff <= nxt_op1;
    end
  end

  // Burst base and word count
  always_ff @(posedge clk) begin
    if (rst) begin
      base_ff <= '0;
      cnt_ff  <= 2'h0;
    end else if (en) begin
      base_ff <= nxt_base;
      cnt_ff  <= nxt_cnt;
    end
  end

  // Array write; memory has no reset
  always_ff @(posedge clk) begin
    if (wr_land) begin
      mem_q[a2_ff] <= pss_merge(mem_q[a2_ff], bus.dq_ctl_o, bw2_ff);
    end
  end

  // Output enable; a held edge keeps it standing
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_ff <= 1'h0;
    end else if (en) begin
      oe_ff <= nxt_oe;
    end
  end

  // Output word; a held edge keeps it on the bus
  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff <= '0;
    end else if (en) begin
      q_ff <= nxt_q;
    end
  end

  // Read data and its enable; the bus is released outside reads
  assign bus.dq_mem_o  = q_ff;
  assign bus.dq_mem_oe = oe_ff;
endmodule

// ---- rtl/pss_ctl.sv ----
`timescale 1ns/1ps
`include "pss_defs.svh"
module pss_ctl
  import pss_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   req_valid,
  input  wire logic                   req_write,
  input  wire logic                   req_burst,
  input  wire logic [`PSS_ADDR_W-1:0] req_addr,
  input  wire logic [`PSS_BYTES-1:0]  req_be,
  input  wire logic [`PSS_DATA_W-1:0] wr_data,
  input  wire logic                   hold,
  input  wire logic                   order_linear,
  output logic                        wr_data_take,
  output logic                        rd_valid,
  output logic [`PSS_DATA_W-1:0]      rd_data,
  pss_if.ctl                          bus
);
  pss_op_e               op1_ff, op2_ff;
  logic                  wde_ff;
  logic [`PSS_DATA_W-1:0] wd_ff;
  logic                  rv_ff;
  logic [`PSS_DATA_W-1:0] rd_ff;

  // Burst request advances; otherwise a load, selected only on valid
  wire en  = ~hold;
  wire adv = req_burst;
  wire pss_op_e nxt_op = adv ? op1_ff
                             : (req_valid ? (req_write ? PSS_WRITE : PSS_READ) : PSS_IDLE);

  assign bus.addr            = req_addr;
  assign bus.read_write_n    = ~req_write;
  assign bus.advance_or_load = adv;
  assign bus.chip_sel_a_n    = ~req_valid;
  assign bus.chip_sel_b      = req_valid;
  assign bus.chip_sel_c_n    = ~req_valid;
  assign bus.clock_hold_n    = hold;
  assign bus.byte_write_n    = ~req_be;
  assign bus.burst_order_n   = ~order_linear;
  assign wr_data_take        = en & (op1_ff == PSS_WRITE);

  // Track loads two enabled edges deep
  always_ff @(posedge clk) begin
    if (rst) begin
      op1_ff <= PSS_IDLE;
      op2_ff <= PSS_IDLE;
      wde_ff <= 1'b0;
      wd_ff  <= '0;
      rv_ff  <= 1'b0;
      rd_ff  <= '0;
    end else if (en) begin
      op1_ff <= nxt_op;
      op2_ff <= op1_ff;
      wde_ff <= (op1_ff == PSS_WRITE);
      wd_ff  <= wr_data;
      rv_ff  <= (op2_ff == PSS_READ) & bus.dq_mem_oe;
      rd_ff  <= bus.dq_mem_o;
    end
  end

  assign bus.dq_ctl_o  = wd_ff;
  assign bus.dq_ctl_oe = wde_ff;
  assign rd_valid      = rv_ff & en;
  assign rd_data       = rd_ff;
endmodule

// ---- sim/pss_checker.sv ----
`timescale 1ns/1ps
module pss_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic read_write_n,
  input wire logic advance_or_load,
  input wire logic chip_sel_a_n,
  input wire logic chip_sel_b,
  input wire logic chip_sel_c_n,
  input wire logic clock_hold_n,
  input wire logic dq_ctl_oe,
  input wire logic dq_mem_oe
);
  // Load decode; an edge counts only when not held
  wire en  = !clock_hold_n;
  wire sel = !chip_sel_a_n && !chip_sel_c_n && chip_sel_b;
  wire ld  = sel && !advance_or_load && en;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence adv_on; advance_or_load && en; endsequence
  AST_RD: assert property (ld && read_write_n ##1 en |=> dq_mem_oe) else $error("rd");
  AST_WR: assert property (ld && !read_write_n ##1 en |=> dq_ctl_oe) else $error("wr");
  AST_WRZ: assert property (ld && !read_write_n ##1 en |=> !dq_mem_oe) else $error("wz");
  AST_DES: assert property (!sel && !advance_or_load && en ##1 en |=> !dq_mem_oe) else $error("ds");
  AST_BURST: assert property (ld && read_write_n ##1 adv_on ##1 adv_on |=> dq_mem_oe) else $error("bu");
  AST_HOLD: assert property (!en |=> $stable(dq_mem_oe)) else $error("ho");
  AST_RST: assert property ($fell(rst) |-> !dq_mem_oe && !dq_ctl_oe) else $error("rs");
  AST_ONE: assert property (!(dq_mem_oe && dq_ctl_oe)) else $error("bo");
endmodule

// ---- sim/pss_tb_top.sv ----
`timescale 1ns/1ps
module pipelined_sram_suspend_deselect_tb_top;
  logic        clk = 1'h0, rst = 1'h1, rv = 1'h0, rw = 1'h0, rb = 1'h0;
  logic        hold = 1'h0, lin = 1'h0, take, rdv;
  logic [16:0] ra = 17'h0;
  logic [3:0]  be = 4'hF;
  logic [35:0] wd = 36'h0, rd, wq[$], rq[$];
  int          n_errors = 0, num_checks = 0;
  pss_if bus_if ();
  pss_sram i_pss_sram (.clk(clk), .rst(rst), .bus(bus_if));
  pss_ctl i_pss_ctl (.clk(clk), .rst(rst), .req_valid(rv), .req_write(rw), .req_burst(rb),
    .req_addr(ra), .req_be(be), .wr_data(wd), .hold(hold), .order_linear(lin),
    .wr_data_take(take), .rd_valid(rdv), .rd_data(rd), .bus(bus_if));
  pss_checker i_chk (.clk(clk), .rst(rst), .read_write_n(bus_if.read_write_n),
    .advance_or_load(bus_if.advance_or_load), .chip_sel_a_n(bus_if.chip_sel_a_n),
    .chip_sel_b(bus_if.chip_sel_b), .chip_sel_c_n(bus_if.chip_sel_c_n),
    .clock_hold_n(bus_if.clock_hold_n), .dq_ctl_oe(bus_if.dq_ctl_oe),
    .dq_mem_oe(bus_if.dq_mem_oe));
  initial forever #5 clk = ~clk;
  // Queue head stays on wr_data until taken; held edges take nothing
  always @(posedge clk) begin
    if (take && !hold) void'(wq.pop_front());
    wd <= wq.size() ? wq[0] : 36'h0;
  end
  // Every read word must match the oldest expectation
  always @(posedge clk) if (rdv === 1'h1) chk(rd, rq.size() ? rq.pop_front() : ~rd);
  task automatic chk(input logic [35:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Request stands until an enabled edge takes it
  task automatic req(input logic w, b, input logic [16:0] a, input logic [3:0] e);
    rv <= 1'h1;
    rw <= w;
    rb <= b;
    ra <= a;
    be <= e;
    do @(posedge clk); while (hold);
  endtask
  task automatic idle(input int n);
    rv <= 1'h0;
    rb <= 1'h0;
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait: all writes taken, all reads returned
  task automatic drain(input string s);
    repeat (60) if (rq.size() || wq.size()) @(posedge clk);
    chk(36'(rq.size() + wq.size()), 36'h0);
    $display("%s done", s);
  endtask
  // Masked overwrite, hold behind a pending write, deselect gaps
  task automatic t_gap;
    wq = '{36'hA_5555_5555, 36'h0_0000_01C3, 36'h1_2345_6789};
    rq = '{36'hA_5555_55C3, 36'h1_2345_6789};
    req(1'h1, 1'h0, 17'h10, 4'hF);
    req(1'h1, 1'h0, 17'h10, 4'h1);
    hold <= 1'h1;
    idle(3);
    hold <= 1'h0;
    req(1'h1, 1'h0, 17'h1FFFF, 4'hF);
    idle(2);
    req(1'h0, 1'h0, 17'h10, 4'hF);
    idle(1);
    req(1'h0, 1'h0, 17'h1FFFF, 4'hF);
    idle(2);
    drain("gap");
    chk(36'({bus_if.dq_mem_oe, bus_if.dq_ctl_oe}), 36'h0);
  endtask
  // Unaligned four-word read burst in both orders
  task automatic t_burst;
    for (int o = 0; o < 2; o++) begin
      lin <= o[0];
      for (int k = 0; k < 4; k++) wq.push_back(36'hB00 + 36'(k));
      // Load with advance low, then three advancing edges
      req(1'h1, 1'h0, 17'h20, 4'hF);
      repeat (3) req(1'h1, 1'h1, 17'h20, 4'hF);
      idle(6);
      for (int k = 0; k < 4; k++) rq.push_back(36'hB00 + 36'(o ? (k + 1) % 4 : k ^ 1));
      req(1'h0, 1'h0, 17'h21, 4'hF);
      repeat (3) req(1'h0, 1'h1, 17'h21, 4'hF);
      idle(6);
      drain("burst");
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(36'({bus_if.dq_mem_oe, bus_if.dq_ctl_oe}), 36'h0);
    t_gap();
    t_burst();
    tally_and_finish();
  end
  // Watchdog, well past the expected run
  initial begin
    #20000;
    n_errors++;
    tally_and_finish();
  end
endmodule
